// ### rtl/mocl_map.vh
// register map, field positions and reset values of the main oscillator control
`ifndef MOCL_MAP_VH
`define MOCL_MAP_VH

`define MOCL_ADDR_W          8
`define MOCL_OFF_OSC_CR_TWO  8'hE2
`define MOCL_OFF_TRIM        8'hE8
`define MOCL_OFF_SYS_SC_ONE  8'hFE
`define MOCL_OFF_BOOT_CTL    8'hF0

`define MOCL_RST_OSC_CR_TWO  8'h00
`define MOCL_RST_TRIM        8'h00
`define MOCL_RST_SYS_SC_ONE  8'h00
`define MOCL_RST_BOOT_CTL    8'h00

`define MOCL_BIT_EXT_SEL     2
`define MOCL_BIT_FAST_EN     4
`define MOCL_BIT_RAM_CLR_DIS 0
`define MOCL_BIT_RANGE_LO    3
`define MOCL_BIT_RANGE_HI    4
`define MOCL_BIT_REPEAT_BOOT 7
`define MOCL_BIT_DBL_OFF     0

`define MOCL_RANGE_12M       2'b00
`define MOCL_RANGE_6M        2'b01
`define MOCL_RANGE_24M       2'b10
`define MOCL_RANGE_RESERVED_BIT      2'b11

`endif

// ### rtl/mocl_sync2.v
// two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module mocl_sync2 #(
    parameter W = 1
) (
    // clock and reset
    input  wire         clk_i,
    input  wire         nrst_i,
    // level in and out
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;

    always @(posedge clk_i) begin
        if (!nrst_i) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
        end
    end

    assign q_o = s2_q;
endmodule // mocl_sync2

// ### rtl/mocl_range_dec.v
// decode of the range-select code to a one-hot frequency choice
`timescale 1ns/1ps
`include "mocl_map.vh"
module mocl_range_dec (
    // code in
    input  wire [1:0] range_i,
    // one-hot select out: bit0 6 MHz, bit1 12 MHz, bit2 24 MHz
    output reg  [2:0] sel_o
);
    always @* begin
        case (range_i)
            `MOCL_RANGE_12M: sel_o = 3'h2;
            `MOCL_RANGE_6M:  sel_o = 3'h1;
            `MOCL_RANGE_24M: sel_o = 3'h4;
            default:         sel_o = 3'h2;
        endcase
    end
endmodule // mocl_range_dec

// ### rtl/mocl_ctrl.v
// main oscillator control: range, trim, doubler, clock source and status bits
// How it works
// - two-bit range code picks 12, 6 or 24 MHz; code 11 reserved
// - a range write reaches the oscillator control outputs at once
// - trim sits in an 8-bit register, bit 0 least significant
// - boot loads the factory trim; the register reset value is zero
// - without external select, system clock comes from the main oscillator
// - external select bit makes the external clock source the whole clock tree
// - fast clock enable bit gates the 48 MHz clock, 1 enables
// - read-only repeat boot flag shows the boot routine ran more than once
// - ram clear disable bit, default 0, picks maximum or minimum SRAM clearing
// - the frequency doubler can be switched off to save power
`timescale 1ns/1ps
`include "mocl_map.vh"
module mocl_ctrl (
    // clock and reset
    input  wire       clk_i,
    input  wire       nrst_i,
    // register port
    input  wire [7:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output reg  [7:0] rdata_o,
    // boot controller
    input  wire       boot_load_i,
    input  wire [7:0] boot_trim_i,
    input  wire       boot_start_i,
    // external clock request state
    input  wire       ext_clk_alive_i,
    // oscillator controls
    output reg  [2:0] range_sel_o,
    output reg  [1:0] range_code_o,
    output reg  [7:0] trim_o,
    output reg        doubler_en_o,
    output reg        fast_clock_en_o,
    output reg        ext_clk_sel_o,
    output reg        ram_clear_min_o,
    output reg        repeat_boot_o,
    output reg        ext_clk_seen_o
);
    // registers
    reg  [7:0] trim_q;
    reg  [1:0] range_q;
    reg        ram_clr_dis_q;
    reg        ext_sel_q;
    reg        fast_en_q;
    reg        dbl_off_q;
    reg        repeat_boot_q;
    reg        boot_seen_q;
    reg  [7:0] rdata_d;
    wire [2:0] sel_w;
    wire       ext_alive_s;

    wire wr_osc  = wr_i && (addr_i == `MOCL_OFF_OSC_CR_TWO);
    wire wr_trim = wr_i && (addr_i == `MOCL_OFF_TRIM);
    wire wr_scr  = wr_i && (addr_i == `MOCL_OFF_SYS_SC_ONE);
    wire wr_boot = wr_i && (addr_i == `MOCL_OFF_BOOT_CTL);

    mocl_range_dec u_dec (
        .range_i (range_q),
        .sel_o   (sel_w)
    );

    mocl_sync2 #(.W(1)) u_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (ext_clk_alive_i),
        .q_o    (ext_alive_s)
    );

    always @(posedge clk_i) begin
        if (!nrst_i) begin
            trim_q        <= `MOCL_RST_TRIM;
            range_q       <= `MOCL_RANGE_12M;
            ram_clr_dis_q <= 1'b0;
            ext_sel_q     <= 1'b0;
            fast_en_q     <= 1'b0;
            dbl_off_q     <= 1'b0;
            repeat_boot_q <= 1'b0;
            boot_seen_q   <= 1'b0;
        end else begin
            if (boot_load_i)
                trim_q <= boot_trim_i;
            else if (wr_trim)
                trim_q <= wdata_i;
            if (wr_scr) begin
                range_q       <= wdata_i[`MOCL_BIT_RANGE_HI:`MOCL_BIT_RANGE_LO];
                ram_clr_dis_q <= wdata_i[`MOCL_BIT_RAM_CLR_DIS];
            end
            if (wr_osc) begin
                ext_sel_q <= wdata_i[`MOCL_BIT_EXT_SEL];
                fast_en_q <= wdata_i[`MOCL_BIT_FAST_EN];
            end
            if (wr_boot)
                dbl_off_q <= wdata_i[`MOCL_BIT_DBL_OFF];
            if (boot_start_i) begin
                boot_seen_q <= 1'b1;
                if (boot_seen_q)
                    repeat_boot_q <= 1'b1;
            end
        end
    end

    // read mux, registered one cycle after the strobe
    always @* begin
        rdata_d = 8'h00;
        case (addr_i)
            `MOCL_OFF_OSC_CR_TWO: begin
                rdata_d[`MOCL_BIT_EXT_SEL] = ext_sel_q;
                rdata_d[`MOCL_BIT_FAST_EN] = fast_en_q;
            end
            `MOCL_OFF_TRIM:
                rdata_d = trim_q;
            `MOCL_OFF_SYS_SC_ONE: begin
                rdata_d[`MOCL_BIT_REPEAT_BOOT]                    = repeat_boot_q;
                rdata_d[`MOCL_BIT_RANGE_HI:`MOCL_BIT_RANGE_LO]    = range_q;
                rdata_d[`MOCL_BIT_RAM_CLR_DIS]                    = ram_clr_dis_q;
            end
            `MOCL_OFF_BOOT_CTL: begin
                rdata_d[`MOCL_BIT_DBL_OFF] = dbl_off_q;
                rdata_d[1]                 = ext_alive_s;
            end
            default:
                rdata_d = 8'h00;
        endcase
    end

    always @(posedge clk_i) begin
        if (!nrst_i)
            rdata_o <= 8'h00;
        else if (rd_i)
            rdata_o <= rdata_d;
        else
            rdata_o <= 8'h00;
    end

    // outputs follow registers combinationally so a range change is immediate
    always @* begin
        range_sel_o     = sel_w;
        range_code_o    = range_q;
        trim_o          = trim_q;
        doubler_en_o    = ~dbl_off_q;
        fast_clock_en_o = fast_en_q;
        ext_clk_sel_o   = ext_sel_q;
        ram_clear_min_o = ram_clr_dis_q;
        repeat_boot_o   = repeat_boot_q;
        ext_clk_seen_o  = ext_alive_s;
    end
endmodule // mocl_ctrl

// ### sim/mocl_ctrl_asserts.sv
// port assertions of the main oscillator control
`timescale 1ns/1ps
module mocl_ctrl_asserts (
    input wire logic       clk_i, nrst_i, wr_i, boot_load_i, repeat_boot_o,
    input wire logic [7:0] addr_i, wdata_i, boot_trim_i, trim_o,
    input wire logic [2:0] range_sel_o,
    input wire logic [1:0] range_code_o,
    input wire logic       doubler_en_o, fast_clock_en_o, ext_clk_sel_o, ram_clear_min_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    wire w_osc = wr_i && addr_i == 8'hE2;
    wire w_sys = wr_i && addr_i == 8'hFE;
    a_range_decode: assert property (range_sel_o == (range_code_o == 2'h1 ? 3'h1 :
        range_code_o == 2'h2 ? 3'h4 : 3'h2)) else $error("range decode wrong");
    a_range_now: assert property (w_sys |=> range_code_o == $past(wdata_i[4:3])) else $error("range late");
    a_ram_clear: assert property (w_sys |=> ram_clear_min_o == $past(wdata_i[0])) else $error("ram bit");
    a_trim_write: assert property (wr_i && addr_i == 8'hE8 && !boot_load_i |=>
        trim_o == $past(wdata_i)) else $error("trim write");
    a_boot_trim: assert property (boot_load_i |=> trim_o == $past(boot_trim_i)) else $error("boot trim");
    a_ext_select: assert property (w_osc |=> ext_clk_sel_o == $past(wdata_i[2])) else $error("ext sel");
    a_fast_enable: assert property (w_osc |=> fast_clock_en_o == $past(wdata_i[4])) else $error("fast en");
    a_doubler_off: assert property (wr_i && addr_i == 8'hF0 |=>
        doubler_en_o != $past(wdata_i[0])) else $error("doubler");
    a_repeat_sticky: assert property (repeat_boot_o |=> repeat_boot_o) else $error("repeat flag lost");
    cover property (w_sys && wdata_i[4:3] == 2'h3);
    cover property (boot_load_i && wr_i);
    cover property ($rose(repeat_boot_o));
endmodule // mocl_ctrl_asserts
bind mocl_ctrl mocl_ctrl_asserts i_mocl_ctrl_asserts (.clk_i, .nrst_i, .wr_i, .boot_load_i, .repeat_boot_o,
    .addr_i, .wdata_i, .boot_trim_i, .trim_o, .range_sel_o, .range_code_o, .doubler_en_o, .fast_clock_en_o,
    .ext_clk_sel_o, .ram_clear_min_o);

// ### sim/mocl_ctrl_tb_top.sv
// self-checking bench of the main oscillator control
`timescale 1ns/1ps
module mocl_ctrl_tb_top;
    logic       clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, bl = 0, bs = 0, ea = 0, rd_d = 0;
    logic [7:0] addr_i = 0, wdata_i = 0, bt = 0, rdata_o, trim_o, v, e;
    logic [2:0] sel;
    logic [1:0] code;
    logic       dbl, fast, ext, ramc, rep, seen;
    logic [7:0] exp_q[$];
    int         n_mismatch = 0, num_checks = 0, seed = 32'h6b22, k;
    always #50 clk_i = ~clk_i;
    mocl_ctrl i_mocl_ctrl (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .boot_load_i(bl), .boot_trim_i(bt), .boot_start_i(bs),
        .ext_clk_alive_i(ea), .range_sel_o(sel), .range_code_o(code), .trim_o(trim_o), .doubler_en_o(dbl),
        .fast_clock_en_o(fast), .ext_clk_sel_o(ext), .ram_clear_min_o(ramc), .repeat_boot_o(rep),
        .ext_clk_seen_o(seen));
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        num_checks++;
        if (got !== want) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask
    // one bus cycle; strobes and data each assigned once per edge
    task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        wr_i <= w;
        rd_i <= r;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        exp_q.push_back(want);
        acc(0, 1, a, 8'h00);
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge clk_i) begin
        if (rd_d && exp_q.size() > 0) chk(rdata_o, exp_q.pop_front());
        rd_d <= rd_i;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge clk_i);
        nrst_i <= 1;
        @(posedge clk_i);
        chk({4'h0, dbl, sel}, 8'h0A);
        chk(trim_o, 8'h00);
        rd(8'hE2, 8'h00);
        rd(8'hE8, 8'h00);
        rd(8'hFE, 8'h00);
        rd(8'hF0, 8'h00);
        $display("reset test done");
        for (k = 0; k < 4; k++) begin
            e = {3'h0, k[1:0], 2'h0, k[0]};
            acc(1, 0, 8'hFE, e);
            rd(8'hFE, e);
            chk({4'h0, ramc, sel}, {4'h0, k[0], k == 1 ? 3'h1 : k == 2 ? 3'h4 : 3'h2});
            chk({6'h0, code}, {6'h0, k[1:0]});
            e = {3'h0, k[1], 1'b0, k[0], 2'h0};
            acc(1, 0, 8'hE2, e);
            rd(8'hE2, e);
            chk({6'h0, fast, ext}, {6'h0, k[1:0]});
        end
        $display("range test done");
        v = $random(seed);
        acc(1, 0, 8'hFE, 8'h08);
        acc(1, 0, 8'hE8, v);
        rd(8'hE8, v);
        bl <= 1;
        bt <= ~v;
        acc(1, 0, 8'hE8, v);
        bl <= 0;
        rd(8'hE8, ~v);
        acc(1, 0, 8'h55, v);
        rd(8'h55, 8'h00);
        acc(1, 0, 8'hF0, 8'h01);
        rd(8'hF0, 8'h01);
        chk({7'h0, dbl}, 8'h00);
        ea <= 1;
        acc(1, 0, 8'hF0, 8'h00);
        repeat (3) acc(0, 0, 8'h00, 8'h00);
        rd(8'hF0, 8'h02);
        chk({6'h0, seen, dbl}, 8'h03);
        $display("trim and doubler test done");
        bs <= 1;
        acc(0, 0, 8'h00, 8'h00);
        bs <= 0;
        rd(8'hFE, 8'h08);
        chk({7'h0, rep}, 8'h00);
        bs <= 1;
        acc(0, 0, 8'h00, 8'h00);
        bs <= 0;
        rd(8'hFE, 8'h88);
        chk({7'h0, rep}, 8'h01);
        repeat (2) acc(0, 0, 8'h00, 8'h00);
        $display("boot test done");
        wrap_up();
    end
endmodule // mocl_ctrl_tb_top
